/* File: include/tk_map.svh */
/*
  Packet layout, register numbers, field positions and reset values of the
  touch-key configuration packet decoder.
  Assumes it is included by bare name from the package and the design files.
*/
`ifndef TK_MAP_SVH
`define TK_MAP_SVH

// fixed packet frame
`define TK_PKT_TYPE 3'h5
`define TK_PKT_TYPE_HI 30
`define TK_PKT_TYPE_LO 28
`define TK_PKT_KIND_HI 27
`define TK_PKT_KIND_LO 24
`define TK_PKT_REG_HI 23
`define TK_PKT_REG_LO 20
`define TK_PKT_EREG_HI 23
`define TK_PKT_EREG_LO 21
`define TK_PKT_DATA_HI 19
`define TK_PKT_DATA_LO 4
`define TK_PKT_EDATA_HI 20
`define TK_PKT_EDATA_LO 1

// packet kinds
`define TK_KIND_RESPONSE 4'h2
`define TK_KIND_READ 4'h3
`define TK_KIND_WRITE 4'h4
`define TK_KIND_WRITE_ALT 4'h5
`define TK_KIND_ENH_RESPONSE 4'h7
`define TK_KIND_ENH_READ 4'h8
`define TK_KIND_ENH_WRITE 4'h9

// register numbers
`define TK_REG_POWER_SAVE_CALIBRATION_SPEED 4'h5
`define TK_REG_RECALIBRATION_TRIGGER 4'h6
`define TK_REG_IDLE_ENTRY_AND_SLAVE_ADDRESS 4'h7
`define TK_REG_TOUCH_TRIGGER_LEVEL 4'ha

// field positions inside the packet word
`define TK_KEY_LEVEL_BIT 16
`define TK_PS_TIME_HI 15
`define TK_PS_TIME_LO 8
`define TK_CAL_SPEED_HI 7
`define TK_CAL_SPEED_LO 4
`define TK_RECAL_BIT 19
`define TK_IDLE_TIME_HI 15
`define TK_IDLE_TIME_LO 8
`define TK_ADDR_HI 7
`define TK_ADDR_LO 1
`define TK_BTN_HI 16
`define TK_BTN_LO 12
`define TK_LEVEL_HI 11
`define TK_LEVEL_LO 4

// reset values
`define TK_RST_KEY_LEVEL 1'h0
`define TK_RST_PS_TIME 8'h64
`define TK_RST_CAL_SPEED 4'h4
`define TK_RST_IDLE_TIME 8'h00
`define TK_RST_ADDR 7'h10
`define TK_RST_LEVEL 8'h30

// buttons
`define TK_NUM_BTN 18
`define TK_BTN_ALL 5'h1f

// completion message after a re-calibration
`define TK_CAL_MSG 32'h00a5a5a5

`endif

/* File: include/tk_pkg.sv */
/*
  Types of the touch-key configuration packet decoder.
  Assumes tk_map.svh is on the include path.
*/
`include "tk_map.svh"

package tk_pkg;

  typedef enum logic [2:0] {
    TK_ST_IDLE = 3'h1,
    TK_ST_DECODE = 3'h2,
    TK_ST_REPLY = 3'h4
  } tk_state_t;

  typedef struct packed {
    tk_state_t state;
    logic fetch;
    logic [2:0] rx_s;
    logic [2:0] done_s;
    logic [1:0] i2c_s;
    logic [31:0] pkt;
    logic [31:0] reply;
    logic is_msg;
    logic req_n;
    logic cal_start;
    logic cal_busy;
    logic cal_ok;
    logic key_hi;
    logic [7:0] ps_time;
    logic [3:0] cal_speed;
    logic [7:0] idle_time;
    logic [6:0] addr;
    logic [7:0][19:0] enh;
  } tk_core_t;

  typedef struct packed {
    logic [1:0] rst_s;
    logic [31:0] rx_word;
    logic rx_tgl;
    logic done_tgl;
  } tk_link_t;

  typedef struct packed {
    logic [`TK_NUM_BTN-1:0][7:0] level;
    logic [7:0] rdata;
  } tk_mem_t;

endpackage

/* File: include/tk_mem_if.sv */
/*
  Port bundle between the packet decoder and its trigger level memory.
  Assumes both ends run on the core clock.
*/
`timescale 1ns/1ns

interface tk_mem_if;
  logic we;
  logic wr_all;
  logic [4:0] waddr;
  logic [7:0] wdata;
  logic [4:0] raddr;
  logic [7:0] rdata;

  modport ctrl (output we, output wr_all, output waddr, output wdata, output raddr,
    input rdata);
  modport mem (input we, input wr_all, input waddr, input wdata, input raddr,
    output rdata);
endinterface

/* File: core/tk_trig_mem.sv */
/*
  Per-button touch trigger level store, one byte per button, registered read.
  Assumes a synchronous active-high reset on the core clock.
*/
`timescale 1ns/1ns
`include "tk_map.svh"

module tk_trig_mem (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  tk_mem_if.mem mem_io
);

  tk_pkg::tk_mem_t r;
  tk_pkg::tk_mem_t next_r;

  always_comb
  begin
    next_r = r;
    for (int i = 0; i < `TK_NUM_BTN; i++)
    begin
      if (mem_io.we && (mem_io.wr_all || mem_io.waddr == 5'(i)))
      begin
        next_r.level[i] = mem_io.wdata;
      end
    end
    if (mem_io.raddr < 5'(`TK_NUM_BTN))
    begin
      next_r.rdata = r.level[mem_io.raddr];
    end
    else
    begin
      next_r.rdata = 8'h00;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      r <= '{level: {`TK_NUM_BTN{`TK_RST_LEVEL}}, rdata: 8'h00};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign mem_io.rdata = r.rdata;

  a_level_kept: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (mem_io.we && !mem_io.wr_all && mem_io.waddr < 5'h12) ##1
    (!mem_io.we && mem_io.raddr == $past(mem_io.waddr))
    |=> mem_io.rdata == $past(mem_io.wdata, 2))
    else $error("trigger level not kept");

  a_level_all: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (mem_io.we && mem_io.wr_all) |=> r.level[0] == $past(mem_io.wdata)
    && r.level[17] == $past(mem_io.wdata))
    else $error("write to all buttons missed");

endmodule

/* File: core/tk_cmd_decoder.sv */
/*
  Command packet decoder of the touch-key controller: takes 32-bit host
  packets from the link, keeps the configuration registers and answers reads.
  Assumes the link side delivers whole packets on its own clock with a one-cycle
  valid, and pulses tx_done once the host has taken the answer word.
*/
// How it works
// - register five read answered with kind 0010
// - bit 16 sets pressed key output level
// - bits 15:8 power saving, zero free-run
// - power saving interval resets to 100
// - bits 7:4 calibration speed, reset 4
// - register five writes are kept
// - register six bit 19 starts calibration
// - calibration done sends A5 A5 A5
// - bits 15:8 idle delay, reset zero
// - I2C mode: bits 7:1 slave address
// - SPI mode: address bits read zero
// - register ten bits 16:12 select button
// - bits 11:4 trigger level, reset 48
// - registers eight, nine unimplemented
// - registers eleven to fifteen unimplemented
// - enhanced response kind 0111 with data
// - request line low until answer taken
`timescale 1ns/1ns
`include "tk_map.svh"

module tk_cmd_decoder (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_clk,
  input wire logic [31:0] i_link_rx_word,
  input wire logic i_link_rx_valid,
  input wire logic i_link_tx_done,
  input wire logic i_i2c_sel,
  input wire logic i_cal_done,
  output logic [31:0] o_tx_word,
  output logic o_host_request_line_n,
  output logic o_cal_start,
  output logic o_key_active_high,
  output logic [7:0] o_power_save_time,
  output logic [3:0] o_cal_speed,
  output logic [7:0] o_idle_time,
  output logic [6:0] o_slave_addr
);

  tk_pkg::tk_core_t r;
  tk_pkg::tk_core_t next_r;
  tk_pkg::tk_link_t l;
  tk_pkg::tk_link_t next_l;
  tk_mem_if mem_bus ();

  logic rx_evt;
  logic done_evt;
  logic [3:0] pkt_kind;
  logic [3:0] pkt_reg;
  logic [2:0] pkt_ereg;
  logic [4:0] pkt_btn;

  function automatic logic frame_ok(input logic [31:0] w);
    frame_ok = !w[31] && w[`TK_PKT_TYPE_HI:`TK_PKT_TYPE_LO] == `TK_PKT_TYPE && w[0];
  endfunction

  function automatic logic [31:0] answer(input logic [3:0] rnum, input logic [15:0] data);
    answer = {1'b0, `TK_PKT_TYPE, `TK_KIND_RESPONSE, rnum, data, 4'h1};
  endfunction

  function automatic logic is_write(input logic [3:0] kind);
    is_write = kind == `TK_KIND_WRITE || kind == `TK_KIND_WRITE_ALT;
  endfunction

  // link side: capture each packet and report it and the answer hand-off by toggles
  always_comb
  begin
    next_l = l;
    // core reset reaches the link side through two flops
    next_l.rst_s = {l.rst_s[0], i_sys_rst};
    if (i_link_rx_valid)
    begin
      next_l.rx_word = i_link_rx_word;
      next_l.rx_tgl = !l.rx_tgl;
    end
    if (i_link_tx_done)
    begin
      next_l.done_tgl = !l.done_tgl;
    end
  end

  always_ff @(posedge i_link_clk)
  begin
    if (l.rst_s[1])
    begin
      l <= '{rst_s: next_l.rst_s, rx_word: 32'h00000000, rx_tgl: 1'h0, done_tgl: 1'h0};
    end
    else
    begin
      l <= next_l;
    end
  end

  assign rx_evt = r.rx_s[2] ^ r.rx_s[1];
  assign done_evt = r.done_s[2] ^ r.done_s[1];
  assign pkt_kind = r.pkt[`TK_PKT_KIND_HI:`TK_PKT_KIND_LO];
  assign pkt_reg = r.pkt[`TK_PKT_REG_HI:`TK_PKT_REG_LO];
  assign pkt_ereg = r.pkt[`TK_PKT_EREG_HI:`TK_PKT_EREG_LO];
  assign pkt_btn = r.pkt[`TK_BTN_HI:`TK_BTN_LO];

  always_comb
  begin
    next_r = r;
    next_r.cal_start = 1'b0;
    next_r.fetch = 1'b0;
    next_r.rx_s = {r.rx_s[1:0], l.rx_tgl};
    next_r.done_s = {r.done_s[1:0], l.done_tgl};
    next_r.i2c_s = {r.i2c_s[0], i_i2c_sel};
    if (r.cal_busy && i_cal_done)
    begin
      next_r.cal_ok = 1'b1;
      next_r.cal_busy = 1'b0;
    end
    mem_bus.we = 1'b0;
    mem_bus.wr_all = 1'b0;
    mem_bus.waddr = pkt_btn;
    mem_bus.wdata = r.pkt[`TK_LEVEL_HI:`TK_LEVEL_LO];
    mem_bus.raddr = pkt_btn;
    case (r.state)
      tk_pkg::TK_ST_IDLE:
      begin
        if (r.cal_ok)
        begin
          next_r.reply = `TK_CAL_MSG;
          next_r.is_msg = 1'b1;
          next_r.req_n = 1'b0;
          // a completion landing in this very cycle stays latched
          next_r.cal_ok = r.cal_busy && i_cal_done;
          next_r.state = tk_pkg::TK_ST_REPLY;
        end
        else if (rx_evt)
        begin
          next_r.pkt = l.rx_word;
          next_r.state = tk_pkg::TK_ST_DECODE;
        end
      end
      tk_pkg::TK_ST_DECODE:
      begin
        next_r.state = tk_pkg::TK_ST_IDLE;
        next_r.is_msg = 1'b0;
        if (r.fetch)
        begin
          // level byte is out of the memory one cycle after the address
          next_r.reply = answer(pkt_reg,
            {r.pkt[19:17], pkt_btn, mem_bus.rdata});
          next_r.req_n = 1'b0;
          next_r.state = tk_pkg::TK_ST_REPLY;
        end
        else if (!frame_ok(r.pkt))
        begin
          next_r.state = tk_pkg::TK_ST_IDLE;
        end
        else if (pkt_kind == `TK_KIND_READ)
        begin
          case (pkt_reg)
            `TK_REG_POWER_SAVE_CALIBRATION_SPEED:
            begin
              next_r.reply = answer(pkt_reg, {3'h0, r.key_hi, r.ps_time, r.cal_speed});
              next_r.req_n = 1'b0;
              next_r.state = tk_pkg::TK_ST_REPLY;
            end
            `TK_REG_IDLE_ENTRY_AND_SLAVE_ADDRESS:
            begin
              next_r.reply = answer(pkt_reg, {4'h0, r.idle_time, 4'h0});
              next_r.reply[`TK_ADDR_HI:`TK_ADDR_LO] = r.i2c_s[1] ? r.addr : 7'h00;
              next_r.req_n = 1'b0;
              next_r.state = tk_pkg::TK_ST_REPLY;
            end
            `TK_REG_TOUCH_TRIGGER_LEVEL:
            begin
              next_r.fetch = 1'b1;
              next_r.state = tk_pkg::TK_ST_DECODE;
            end
            default:
            begin
              next_r.state = tk_pkg::TK_ST_IDLE;
            end
          endcase
        end
        else if (is_write(pkt_kind))
        begin
          case (pkt_reg)
            `TK_REG_POWER_SAVE_CALIBRATION_SPEED:
            begin
              next_r.key_hi = r.pkt[`TK_KEY_LEVEL_BIT];
              next_r.ps_time = r.pkt[`TK_PS_TIME_HI:`TK_PS_TIME_LO];
              next_r.cal_speed = r.pkt[`TK_CAL_SPEED_HI:`TK_CAL_SPEED_LO];
            end
            `TK_REG_RECALIBRATION_TRIGGER:
            begin
              if (r.pkt[`TK_RECAL_BIT])
              begin
                next_r.cal_start = 1'b1;
                next_r.cal_busy = 1'b1;
              end
            end
            `TK_REG_IDLE_ENTRY_AND_SLAVE_ADDRESS:
            begin
              next_r.idle_time = r.pkt[`TK_IDLE_TIME_HI:`TK_IDLE_TIME_LO];
              if (r.i2c_s[1])
              begin
                next_r.addr = r.pkt[`TK_ADDR_HI:`TK_ADDR_LO];
              end
            end
            `TK_REG_TOUCH_TRIGGER_LEVEL:
            begin
              // reserved selections 18 to 30 write nothing
              mem_bus.we = pkt_btn < 5'(`TK_NUM_BTN) || pkt_btn == `TK_BTN_ALL;
              mem_bus.wr_all = pkt_btn == `TK_BTN_ALL;
            end
            default:
            begin
              next_r.state = tk_pkg::TK_ST_IDLE;
            end
          endcase
        end
        else if (pkt_kind == `TK_KIND_ENH_READ)
        begin
          next_r.reply = {1'b0, `TK_PKT_TYPE, `TK_KIND_ENH_RESPONSE, pkt_ereg,
            r.enh[pkt_ereg], 1'b1};
          next_r.req_n = 1'b0;
          next_r.state = tk_pkg::TK_ST_REPLY;
        end
        else if (pkt_kind == `TK_KIND_ENH_WRITE)
        begin
          next_r.enh[pkt_ereg] = r.pkt[`TK_PKT_EDATA_HI:`TK_PKT_EDATA_LO];
        end
      end
      tk_pkg::TK_ST_REPLY:
      begin
        // new packets are dropped until the host has the answer
        if (done_evt)
        begin
          next_r.req_n = 1'b1;
          next_r.state = tk_pkg::TK_ST_IDLE;
        end
      end
      default:
      begin
        next_r.state = tk_pkg::TK_ST_IDLE;
        next_r.req_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      r <= '0;
      r.state <= tk_pkg::TK_ST_IDLE;
      r.req_n <= 1'b1;
      r.key_hi <= `TK_RST_KEY_LEVEL;
      r.ps_time <= `TK_RST_PS_TIME;
      r.cal_speed <= `TK_RST_CAL_SPEED;
      r.idle_time <= `TK_RST_IDLE_TIME;
      r.addr <= `TK_RST_ADDR;
    end
    else
    begin
      r <= next_r;
    end
  end

  tk_trig_mem u_trig_mem (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .mem_io(mem_bus.mem)
  );

  assign o_tx_word = r.reply;
  assign o_host_request_line_n = r.req_n;
  assign o_cal_start = r.cal_start;
  assign o_key_active_high = r.key_hi;
  assign o_power_save_time = r.ps_time;
  assign o_cal_speed = r.cal_speed;
  assign o_idle_time = r.idle_time;
  assign o_slave_addr = r.addr;

  a_reply_line_low: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (r.state == tk_pkg::TK_ST_REPLY && !done_evt) |=> !o_host_request_line_n)
    else $error("request line rose before answer taken");

  a_line_release: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (r.state == tk_pkg::TK_ST_REPLY && done_evt) |=> o_host_request_line_n
    && r.state == tk_pkg::TK_ST_IDLE)
    else $error("request line not released");

  a_reply_frame: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (!o_host_request_line_n && !r.is_msg) |-> !o_tx_word[31]
    && o_tx_word[30:28] == 3'h5 && o_tx_word[0])
    else $error("answer frame malformed");

  a_reset_values: assert property (@(posedge i_core_clk)
    $fell(i_sys_rst) |-> o_power_save_time == 8'h64 && o_cal_speed == 4'h4
    && o_idle_time == 8'h00 && o_slave_addr == 7'h10)
    else $error("reset values wrong");

  a_reg5_answer: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (r.state == tk_pkg::TK_ST_DECODE && !r.fetch && frame_ok(r.pkt) && pkt_kind == 4'h3
    && pkt_reg == 4'h5) |=> o_tx_word[27:24] == 4'h2 && o_tx_word[16] == o_key_active_high
    && o_tx_word[15:8] == o_power_save_time && !o_host_request_line_n)
    else $error("register five answer wrong");

  a_reg5_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (r.state == tk_pkg::TK_ST_DECODE && !r.fetch && frame_ok(r.pkt) && is_write(pkt_kind)
    && pkt_reg == 4'h5) |=> o_power_save_time == $past(r.pkt[15:8])
    && o_cal_speed == $past(r.pkt[7:4]) && o_key_active_high == $past(r.pkt[16]))
    else $error("register five write not kept");

  a_spi_addr_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (r.state == tk_pkg::TK_ST_DECODE && !r.fetch && frame_ok(r.pkt) && pkt_kind == 4'h3
    && pkt_reg == 4'h7 && !r.i2c_s[1]) |=> o_tx_word[7:1] == 7'h00)
    else $error("address bits not zero in SPI mode");

  a_recal_start: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (r.state == tk_pkg::TK_ST_DECODE && !r.fetch && frame_ok(r.pkt) && is_write(pkt_kind)
    && pkt_reg == 4'h6) |=> o_cal_start == $past(r.pkt[19]) ##1 !o_cal_start)
    else $error("calibration start wrong");

  a_cal_message: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (r.state == tk_pkg::TK_ST_IDLE && r.cal_ok) |=> o_tx_word == 32'h00a5a5a5
    && !o_host_request_line_n)
    else $error("calibration message not sent");

  a_unimpl_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (r.state == tk_pkg::TK_ST_DECODE && !r.fetch && is_write(pkt_kind)
    && (pkt_reg == 4'h8 || pkt_reg == 4'h9 || pkt_reg > 4'ha))
    |=> $stable(o_power_save_time) && $stable(o_idle_time) && $stable(o_slave_addr)
    && !o_cal_start)
    else $error("unimplemented register write changed state");

  a_enh_answer: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (r.state == tk_pkg::TK_ST_DECODE && !r.fetch && frame_ok(r.pkt) && pkt_kind == 4'h8)
    |=> o_tx_word[27:24] == 4'h7 && o_tx_word[23:21] == $past(pkt_ereg))
    else $error("enhanced answer wrong");

endmodule

/* File: dv/tk_host_model.sv */
/*
  Host-side partner: sends command words over the link and takes answers.
  Assumes the link clock may stand still between frames and is made here.
*/
`timescale 1ns/1ns

module tk_host_model (
  input wire logic i_req_n,
  output logic o_link_clk,
  output logic [31:0] o_rx_word,
  output logic o_rx_valid,
  output logic o_tx_done
);
  initial
  begin
    o_link_clk = 1'b0;
    o_rx_word = 32'h0;
    o_rx_valid = 1'b0;
    o_tx_done = 1'b0;
  end

  // link clock runs only while the host has something going on
  task automatic tick(input int n);
    repeat (n)
    begin
      #24 o_link_clk = 1'b1;
      #24 o_link_clk = 1'b0;
    end
  endtask

  // an impolite send ignores the request line on purpose
  task automatic send(input logic [31:0] w, input logic polite);
    if (polite)
      wait (i_req_n === 1'b1);
    o_rx_word = w;
    o_rx_valid = 1'b1;
    tick(1);
    o_rx_valid = 1'b0;
    o_rx_word = ~w;
    tick(4);
  endtask

  // slow hosts take their time before finishing the receive
  task automatic ack(input int slow);
    #(slow);
    o_tx_done = 1'b1;
    tick(1);
    o_tx_done = 1'b0;
    tick(4);
  endtask
endmodule

/* File: dv/tk_cmd_decoder_tb_top.sv */
/*
  Self-checking bench of the touch-key command decoder.
  Assumes tk_map.svh on the include path and the host model beside it.
*/
`timescale 1ns/1ns
`include "tk_map.svh"

module tk_cmd_decoder_tb_top;
  typedef struct {logic sel; logic [31:0] w; logic rep; logic [31:0] exp;} tk_row_t;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_i2c_sel = 1'b0;
  logic i_cal_done = 1'b0;
  logic link_clk, rx_valid, tx_done, line_n, cal_start, key_hi;
  logic [31:0] rx_word, tx_word;
  logic [7:0] ps_time, idle_time;
  logic [3:0] cal_speed;
  logic [6:0] slave_addr;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_start = 0;
  tk_row_t rows[$];
  logic [3:0] unimpl[7] = '{4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};

  always #4 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (cal_start === 1'b1) n_start++;

  tk_cmd_decoder dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_link_clk(link_clk),
    .i_link_rx_word(rx_word), .i_link_rx_valid(rx_valid), .i_link_tx_done(tx_done),
    .i_i2c_sel(i_i2c_sel), .i_cal_done(i_cal_done), .o_tx_word(tx_word),
    .o_host_request_line_n(line_n), .o_cal_start(cal_start), .o_key_active_high(key_hi),
    .o_power_save_time(ps_time), .o_cal_speed(cal_speed), .o_idle_time(idle_time),
    .o_slave_addr(slave_addr));
  tk_host_model host (.i_req_n(line_n), .o_link_clk(link_clk), .o_rx_word(rx_word),
    .o_rx_valid(rx_valid), .o_tx_done(tx_done));

  function automatic logic [31:0] pk(input logic [3:0] k, input logic [3:0] r,
    input logic [15:0] d);
    return {1'b0, `TK_PKT_TYPE, k, r, d, 3'h0, 1'b1};
  endfunction
  function automatic logic [31:0] ek(input logic [3:0] k, input logic [2:0] r,
    input logic [19:0] d);
    return {1'b0, `TK_PKT_TYPE, k, r, d, 1'b1};
  endfunction
  function automatic logic [31:0] rd(input logic [3:0] r, input logic [15:0] d);
    return pk(`TK_KIND_READ, r, d);
  endfunction
  function automatic logic [31:0] rp(input logic [3:0] r, input logic [15:0] d);
    return pk(`TK_KIND_RESPONSE, r, d);
  endfunction
  function automatic logic [31:0] wr(input logic [3:0] r, input logic [15:0] d);
    return pk(`TK_KIND_WRITE, r, d);
  endfunction

  task automatic add(input logic s, input logic [31:0] w, input logic r, input logic [31:0] e);
    rows.push_back('{s, w, r, e});
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wait_line(input logic v);
    int i;
    i = 0;
    while (line_n !== v && i < 100)
    begin
      @(posedge i_core_clk);
      #1;
      i++;
    end
    chk({31'h0, line_n}, {31'h0, v});
  endtask

  task automatic xact(input tk_row_t r, input int slow);
    @(posedge i_core_clk);
    #1 i_i2c_sel = r.sel;
    repeat (4) @(posedge i_core_clk);
    host.send(r.w, 1'b1);
    if (r.rep)
    begin
      wait_line(1'b0);
      chk(tx_word, r.exp);
      host.ack(slow);
      wait_line(1'b1);
    end
    else
    begin
      repeat (40) @(posedge i_core_clk);
      #1 chk({31'h0, line_n}, 32'h1);
    end
  endtask

  task automatic do_reset();
    @(posedge i_core_clk);
    #1 i_sys_rst = 1'b1;
    fork
      host.tick(4);
      repeat (8) @(posedge i_core_clk);
    join
    @(posedge i_core_clk);
    #1 i_sys_rst = 1'b0;
    // the link side leaves reset two link edges after the core
    host.tick(3);
    @(posedge i_core_clk);
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_mismatch++;
    $display("unexpected at %0t: timeout", $time);
    end_sim();
  end

  initial
  begin
    do_reset();
    chk({24'h0, ps_time}, 32'h64);
    chk({28'h0, cal_speed}, 32'h4);
    chk({24'h0, idle_time}, 32'h0);
    chk({25'h0, slave_addr}, 32'h10);
    chk({31'h0, key_hi}, 32'h0);
    chk({31'h0, line_n}, 32'h1);
    add(0, rd(4'h5, 0), 1, rp(4'h5, 16'h0644));
    add(0, wr(4'h5, 16'h1123), 0, 0);
    add(0, rd(4'h5, 0), 1, rp(4'h5, 16'h1123));
    add(0, pk(`TK_KIND_WRITE_ALT, 4'h5, 16'h100f), 0, 0);
    add(0, rd(4'h5, 0), 1, rp(4'h5, 16'h100f));
    add(0, rd(4'h7, 0), 1, rp(4'h7, 16'h0000));
    add(0, wr(4'h7, 16'h0554), 0, 0);
    add(0, rd(4'h7, 0), 1, rp(4'h7, 16'h0550));
    add(1, rd(4'h7, 0), 1, rp(4'h7, 16'h0552));
    add(1, wr(4'h7, 16'h0554), 0, 0);
    add(1, rd(4'h7, 0), 1, rp(4'h7, 16'h0554));
    add(1, rd(4'ha, 16'h0000), 1, rp(4'ha, 16'h0030));
    add(1, wr(4'ha, 16'h1114), 0, 0);
    add(1, rd(4'ha, 16'h1100), 1, rp(4'ha, 16'h1114));
    add(1, rd(4'ha, 16'h1000), 1, rp(4'ha, 16'h1030));
    add(1, wr(4'ha, 16'h1455), 0, 0);
    add(1, rd(4'ha, 16'h1400), 1, rp(4'ha, 16'h1400));
    add(1, wr(4'ha, 16'h1f22), 0, 0);
    add(1, rd(4'ha, 16'h0300), 1, rp(4'ha, 16'h0322));
    add(1, rd(4'ha, 16'h1f00), 1, rp(4'ha, 16'h1f00));
    add(1, rd(4'h6, 0), 0, 0);
    foreach (unimpl[i])
    begin
      add(1, wr(unimpl[i], 16'hffff), 0, 0);
      add(1, rd(unimpl[i], 0), 0, 0);
    end
    add(1, rd(4'h5, 0), 1, rp(4'h5, 16'h100f));
    add(1, rd(4'h7, 0), 1, rp(4'h7, 16'h0554));
    add(1, ek(`TK_KIND_ENH_WRITE, 3'h4, 20'h3c5a1), 0, 0);
    add(1, ek(`TK_KIND_ENH_READ, 3'h4, 0), 1,
      ek(`TK_KIND_ENH_RESPONSE, 3'h4, 20'h3c5a1));
    add(1, ek(`TK_KIND_ENH_READ, 3'h2, 0), 1, ek(`TK_KIND_ENH_RESPONSE, 3'h2, 0));
    add(1, rd(4'h5, 0) | 32'h80000000, 0, 0);
    add(1, rd(4'h5, 0) & 32'hfffffffe, 0, 0);
    add(1, rd(4'h5, 0) ^ 32'h10000000, 0, 0);
    foreach (rows[i])
      xact(rows[i], (i % 3) * 150);
    chk({31'h0, key_hi}, 32'h1);
    chk({24'h0, ps_time}, 32'h0);
    chk({28'h0, cal_speed}, 32'hf);
    chk({24'h0, idle_time}, 32'h55);
    chk({25'h0, slave_addr}, 32'h20);
    // a command sent while an answer is pending must be dropped
    host.send(rd(4'h5, 0), 1'b1);
    wait_line(1'b0);
    host.send(rd(4'h7, 0), 1'b0);
    chk(tx_word, rp(4'h5, 16'h100f));
    host.ack(0);
    wait_line(1'b1);
    repeat (40) @(posedge i_core_clk);
    #1 chk({31'h0, line_n}, 32'h1);
    xact('{1, wr(4'h6, 16'h0000), 0, 0}, 0);
    chk(n_start, 0);
    xact('{1, wr(4'h6, 16'h8000), 0, 0}, 0);
    chk(n_start, 1);
    @(posedge i_core_clk);
    #1 i_cal_done = 1'b1;
    @(posedge i_core_clk);
    #1 i_cal_done = 1'b0;
    wait_line(1'b0);
    chk(tx_word, {8'h00, 8'ha5, 8'ha5, 8'ha5});
    host.ack(0);
    wait_line(1'b1);
    do_reset();
    xact('{0, rd(4'h5, 0), 1, rp(4'h5, 16'h0644)}, 0);
    xact('{1, rd(4'h7, 0), 1, rp(4'h7, 16'h0002)}, 0);
    end_sim();
  end
endmodule
